//--- udpc_defs.svh
// Constants of the USB device DMA packet control block.
// Assumes inclusion by bare name from the design file.
`ifndef UDPC_DEFS_SVH
`define UDPC_DEFS_SVH
// -----------------------------------------------------------------
// Register byte addresses
// -----------------------------------------------------------------
`define UDPC_OFS_TXCNT 32'h4980_0038
`define UDPC_OFS_MAX_PACKET_BYTES  32'h4980_003c
`define UDPC_OFS_DCTL  32'h4980_0040
`define UDPC_OFS_DTC   32'h4980_0044
`define UDPC_OFS_DFC   32'h4980_0048
// -----------------------------------------------------------------
// Field widths, positions and limits
// -----------------------------------------------------------------
`define UDPC_TXCNT_W   10
`define UDPC_MAX_PACKET_BYTES_W    11
`define UDPC_DTC_W     11
`define UDPC_DFC_W     12
`define UDPC_DCTL_W    6
`define UDPC_MAX_PACKET_BYTES_LIM  11'h400
`define UDPC_B_ARDIS   5
`define UDPC_B_BURST   4
`define UDPC_B_DEMAND  3
`define UDPC_B_TXRUN   2
`define UDPC_B_RXRUN   1
`define UDPC_B_DMA     0
// -----------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------
`define UDPC_RST_TXCNT 10'h000
`define UDPC_RST_MAX_PACKET_BYTES  11'h000
`define UDPC_RST_DCTL  6'h00
`define UDPC_RST_DTC   11'h000
`define UDPC_RST_DFC   12'h000
`define UDPC_RDZERO    32'h0000_0000
`endif

//--- udpc_pkg.sv
// Types of the USB device DMA packet control block.
// Assumes nothing of its surroundings.
`default_nettype none
package udpc_pkg;
	// Register selected by the bus address.
	typedef enum logic [2:0] {
		SEL_NONE, SEL_TXCNT, SEL_MAX_PACKET_BYTES, SEL_DCTL, SEL_DTC, SEL_DFC
	} udpc_sel_t;
	// Progress of the transmit packet byte tracker.
	typedef enum logic {TX_IDLE, TX_BUSY} udpc_tx_t;
endpackage
`default_nettype wire

//--- udpc_top.sv
// Packet length and DMA run control for a USB device data endpoint.
// Assumes an APB master on pclk and endpoint logic on the same clock.
//
// Function
// [RL1] Software loads transmit byte count before sending.
// [RL2] Programmed count marks end of transmit packet.
// [RL3] Software keeps count below max packet size.
// [RL4] Eleven-bit max packet size, zero to 1024.
// [RL5] Bit 5 zero allows auto receive run.
// [RL6] Hardware clears auto-run disable on DMA end.
// [RL7] Bit 4 selects burst mode DMA.
// [RL8] Bit 3 selects demand mode DMA.
// [RL9] Bit 2 starts or stops transmit DMA.
// [RL10] OUT packet sets receive run when allowed.
// [RL11] Software sets receive run to move data.
// [RL12] Bit 0 picks interrupt or DMA mode.
// [RL13] Software programs transfer counter two for single.
// [RL14] Software programs max packet for burst mode.
// [RL15] Received size loads FIFO counter on run.
// [RL16] Software loads FIFO counter for IN endpoint.
// [RL17] Total counter zero ends the DMA operation.
// [RL18] Reserved bits read zero, writes ignored.
`include "udpc_defs.svh"
`default_nettype none
module udpc_top
	import udpc_pkg::*;
(
	input  wire logic                    pclk,               // Bus clock, 10 MHz.
	input  wire logic                    presetn,            // Async reset, active low.
	input  wire logic                    pclken,             // Clock enable, freezes all.
	input  wire logic                    psel,               // APB select.
	input  wire logic                    penable,            // APB access phase.
	input  wire logic                    pwrite,             // APB write direction.
	input  wire logic [31:0]             paddr,              // APB byte address.
	input  wire logic [31:0]             pwdata,             // APB write data.
	output logic                         pready,             // APB ready.
	output logic [31:0]                  prdata,             // APB read data.
	output logic                         pslverr,            // APB error on unmapped.
	input  wire logic                    tx_packet_start,    // Pulse, IN packet begins.
	input  wire logic                    tx_byte_strobe,     // Pulse, one byte sent.
	output logic                         tx_packet_end,      // Pulse, packet ends.
	input  wire logic                    rx_out_packet,      // Pulse, OUT packet received.
	input  wire logic [`UDPC_DFC_W-1:0]  rx_packet_size,     // Size of received packet.
	input  wire logic                    dma_total_zero,     // Pulse, total count hit 0.
	output logic [`UDPC_MAX_PACKET_BYTES_W-1:0]      max_packet_bytes,   // Max packet size.
	output logic [`UDPC_DTC_W-1:0]       dma_transfer_count, // Transfer counter.
	output logic [`UDPC_DFC_W-1:0]       dma_fifo_count,     // FIFO counter.
	output logic                         burst_mode_enable,  // Burst mode DMA.
	output logic                         demand_mode_enable, // Demand mode DMA.
	output logic                         tx_dma_run,         // Transmit DMA running.
	output logic                         rx_dma_run,         // Receive DMA running.
	output logic                         dma_mode_select     // 0 interrupt, 1 DMA.
);
	// -----------------------------------------------------------------
	// Bus decode
	// -----------------------------------------------------------------
	logic                   wr_en;
	logic                   setup;
	udpc_sel_t              sel;
	logic [`UDPC_TXCNT_W-1:0] txcnt_r, txcnt_nxt;
	logic [`UDPC_MAX_PACKET_BYTES_W-1:0]  max_packet_bytes_r, max_packet_bytes_nxt;
	logic [`UDPC_DCTL_W-1:0]  dctl_r, dctl_nxt;
	logic [`UDPC_DTC_W-1:0]   dtc_r, dtc_nxt;
	logic [`UDPC_DFC_W-1:0]   dfc_r, dfc_nxt;
	logic [31:0]            rdata_r, rdata_nxt;
	logic                   err_r, err_nxt;

	// Address decode; the slave waits only while pclken is low, so ready follows the clock enable.
	always_comb begin
		case (paddr)
			`UDPC_OFS_TXCNT: sel = SEL_TXCNT;
			`UDPC_OFS_MAX_PACKET_BYTES:  sel = SEL_MAX_PACKET_BYTES;
			`UDPC_OFS_DCTL:  sel = SEL_DCTL;
			`UDPC_OFS_DTC:   sel = SEL_DTC;
			`UDPC_OFS_DFC:   sel = SEL_DFC;
			default:         sel = SEL_NONE;
		endcase
	end
	assign setup  = psel & ~penable & pclken;
	assign wr_en  = psel & penable & pwrite & pclken & (sel != SEL_NONE);
	assign pready = pclken;

	// Read data is captured in the setup cycle so that it leaves a flip-flop.
	always_comb begin
		rdata_nxt = rdata_r;
		err_nxt   = err_r;
		if (setup) begin
			err_nxt   = (sel == SEL_NONE);
			rdata_nxt = `UDPC_RDZERO;
			case (sel)
				SEL_TXCNT: rdata_nxt[`UDPC_TXCNT_W-1:0] = txcnt_r; // RL18
				SEL_MAX_PACKET_BYTES:  rdata_nxt[`UDPC_MAX_PACKET_BYTES_W-1:0]  = max_packet_bytes_r;  // RL18
				SEL_DCTL:  rdata_nxt[`UDPC_DCTL_W-1:0]  = dctl_r;  // RL18
				SEL_DTC:   rdata_nxt[`UDPC_DTC_W-1:0]   = dtc_r;   // RL18
				SEL_DFC:   rdata_nxt[`UDPC_DFC_W-1:0]   = dfc_r;   // RL18
				default:   rdata_nxt = `UDPC_RDZERO;
			endcase
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_r <= `UDPC_RDZERO;
			err_r   <= 1'b0;
		end else begin
			rdata_r <= rdata_nxt;
			err_r   <= err_nxt;
		end
	end
	assign prdata  = rdata_r;
	assign pslverr = err_r & psel & penable;

	// -----------------------------------------------------------------
	// Register file
	// -----------------------------------------------------------------
	logic auto_set;

	// Software writes take the bus word over the DMA end clear; other hardware events then act on top of them.
	// An OUT packet set wins over a software clear of the receive run bit,
	// while a software write of the disable bit wins over the DMA end clear,
	// since that write is the newer intent of software.
	always_comb begin
		txcnt_nxt = txcnt_r;
		max_packet_bytes_nxt  = max_packet_bytes_r;
		dctl_nxt  = dctl_r;
		dtc_nxt   = dtc_r;
		dfc_nxt   = dfc_r;
		if (pclken && dma_total_zero) begin
			dctl_nxt[`UDPC_B_ARDIS] = 1'b0; // RL6 RL17
		end
		if (wr_en) begin
			case (sel)
				SEL_TXCNT: txcnt_nxt = pwdata[`UDPC_TXCNT_W-1:0]; // RL1 RL18
				SEL_MAX_PACKET_BYTES: begin
					// Sizes above 1024 are clipped so the field stays in range.
					if (pwdata[`UDPC_MAX_PACKET_BYTES_W-1:0] > `UDPC_MAX_PACKET_BYTES_LIM) begin
						max_packet_bytes_nxt = `UDPC_MAX_PACKET_BYTES_LIM; // RL4
					end else begin
						max_packet_bytes_nxt = pwdata[`UDPC_MAX_PACKET_BYTES_W-1:0]; // RL4
					end
				end
				SEL_DCTL: dctl_nxt = pwdata[`UDPC_DCTL_W-1:0]; // RL7 RL8 RL9 RL11 RL12
				SEL_DTC:  dtc_nxt  = pwdata[`UDPC_DTC_W-1:0];  // RL13 RL14
				SEL_DFC:  dfc_nxt  = pwdata[`UDPC_DFC_W-1:0];  // RL16
				default:  txcnt_nxt = txcnt_r;
			endcase
		end
		if (auto_set) begin
			dctl_nxt[`UDPC_B_RXRUN] = 1'b1; // RL10
		end
		// A rising run bit, set by hardware or software, loads the received size.
		if (!dctl_r[`UDPC_B_RXRUN] && dctl_nxt[`UDPC_B_RXRUN]) begin
			dfc_nxt = rx_packet_size; // RL15
		end
	end
	// Auto run needs DMA mode on and the disable bit clear.
	assign auto_set = pclken & rx_out_packet & dctl_r[`UDPC_B_DMA]
		& ~dctl_r[`UDPC_B_ARDIS]; // RL5 RL10

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			txcnt_r <= `UDPC_RST_TXCNT;
			max_packet_bytes_r  <= `UDPC_RST_MAX_PACKET_BYTES;
			dctl_r  <= `UDPC_RST_DCTL;
			dtc_r   <= `UDPC_RST_DTC;
			dfc_r   <= `UDPC_RST_DFC;
		end else begin
			txcnt_r <= txcnt_nxt;
			max_packet_bytes_r  <= max_packet_bytes_nxt;
			dctl_r  <= dctl_nxt;
			dtc_r   <= dtc_nxt;
			dfc_r   <= dfc_nxt;
		end
	end
	assign max_packet_bytes   = max_packet_bytes_r;
	assign dma_transfer_count = dtc_r;
	assign dma_fifo_count     = dfc_r;
	assign burst_mode_enable  = dctl_r[`UDPC_B_BURST];  // RL7
	assign demand_mode_enable = dctl_r[`UDPC_B_DEMAND]; // RL8
	assign tx_dma_run         = dctl_r[`UDPC_B_TXRUN];  // RL9
	assign rx_dma_run         = dctl_r[`UDPC_B_RXRUN];
	assign dma_mode_select    = dctl_r[`UDPC_B_DMA];    // RL12

	// -----------------------------------------------------------------
	// Transmit packet end tracking
	// -----------------------------------------------------------------
	udpc_tx_t                 tx_st_r, tx_st_nxt;
	logic [`UDPC_TXCNT_W-1:0] sent_r, sent_nxt;
	logic                     end_r, end_nxt;

	// The count is compared against the programmed length, so a length
	// changed mid-packet takes effect at once; software must not do that.
	always_comb begin
		tx_st_nxt = tx_st_r;
		sent_nxt  = sent_r;
		end_nxt   = end_r;
		if (pclken) begin
			end_nxt = 1'b0;
			case (tx_st_r)
				TX_IDLE: begin
					if (tx_packet_start) begin
						sent_nxt = '0;
						if (txcnt_r == '0) begin
							end_nxt = 1'b1; // RL2
						end else begin
							tx_st_nxt = TX_BUSY;
						end
					end
				end
				TX_BUSY: begin
					if (tx_byte_strobe) begin
						sent_nxt = sent_r + 1'b1;
						if (sent_nxt == txcnt_r) begin
							end_nxt   = 1'b1; // RL2
							tx_st_nxt = TX_IDLE;
						end
					end
				end
				default: tx_st_nxt = TX_IDLE;
			endcase
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_st_r <= TX_IDLE;
			sent_r  <= '0;
			end_r   <= 1'b0;
		end else begin
			tx_st_r <= tx_st_nxt;
			sent_r  <= sent_nxt;
			end_r   <= end_nxt;
		end
	end
	assign tx_packet_end = end_r;

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic dctl_wr;
	assign dctl_wr = wr_en & (sel == SEL_DCTL);

	sequence s_last_byte;
		pclken && tx_st_r == TX_BUSY && tx_byte_strobe && sent_r + 1'b1 == txcnt_r;
	endsequence
	sequence s_end_pulse;
		tx_packet_end ##1 (!tx_packet_end || tx_st_r == TX_IDLE);
	endsequence

	AST_TX_END: assert property (s_last_byte |=> s_end_pulse) // RL2
		else $error("Transmit packet end missed at the programmed count.");
	AST_MAX_PACKET_BYTES_RANGE: assert property (max_packet_bytes <= `UDPC_MAX_PACKET_BYTES_LIM) // RL4
		else $error("Max packet size above 1024.");
	AST_NO_AUTO: assert property (pclken && rx_out_packet && dctl_r[`UDPC_B_ARDIS] // RL5
		&& !rx_dma_run && !dctl_wr |=> !rx_dma_run)
		else $error("Receive run set while auto run disabled.");
	AST_ARD_CLR: assert property (pclken && dma_total_zero && !dctl_wr // RL6 RL17
		|=> !dctl_r[`UDPC_B_ARDIS])
		else $error("Auto run disable not cleared at DMA end.");
	// Nothing but a control write or a DMA end may move the disable bit.
	AST_ARD_HOLD: assert property (!(pclken && dma_total_zero) && !dctl_wr // RL6 RL17
		|=> dctl_r[`UDPC_B_ARDIS] == $past(dctl_r[`UDPC_B_ARDIS]))
		else $error("Auto run disable moved with no cause.");
	AST_MODES: assert property (dctl_wr // RL7 RL8 RL12
		|=> burst_mode_enable == $past(pwdata[`UDPC_B_BURST])
		&& demand_mode_enable == $past(pwdata[`UDPC_B_DEMAND])
		&& dma_mode_select == $past(pwdata[`UDPC_B_DMA]))
		else $error("Mode bits do not follow the control write.");
	AST_TX_RUN: assert property (dctl_wr // RL9
		|=> tx_dma_run == $past(pwdata[`UDPC_B_TXRUN])
		##1 (tx_dma_run == $past(tx_dma_run) || $past(dctl_wr)))
		else $error("Transmit run does not follow the control write.");
	AST_AUTO_RUN: assert property (pclken && rx_out_packet && dma_mode_select // RL5 RL10
		&& !dctl_r[`UDPC_B_ARDIS] |=> rx_dma_run)
		else $error("OUT packet did not set receive run.");
	// The run bit is a level: only an allowed OUT packet or a control write moves it.
	AST_RX_HOLD: assert property (!auto_set && !dctl_wr // RL10 RL11
		|=> rx_dma_run == $past(rx_dma_run))
		else $error("Receive run moved with no cause.");
	AST_FIFO_LOAD: assert property ($rose(rx_dma_run) // RL15
		|-> dma_fifo_count == $past(rx_packet_size))
		else $error("FIFO counter not loaded with received size.");
	AST_RSVD: assert property (setup && !pwrite && sel == SEL_DCTL // RL18
		|=> prdata[31:`UDPC_DCTL_W] == '0)
		else $error("Reserved control bits read nonzero.");
	AST_RSVD_FIFO: assert property (setup && !pwrite && sel == SEL_DFC // RL18
		|=> prdata[31:`UDPC_DFC_W] == '0)
		else $error("Reserved FIFO counter bits read nonzero.");
	// An empty packet ends at once; an idle tracker ignores stray strobes.
	AST_ZERO_END: assert property (pclken && tx_st_r == TX_IDLE && tx_packet_start // RL2
		&& txcnt_r == '0 |=> tx_packet_end)
		else $error("Zero-length packet end missed.");
	AST_TX_QUIET: assert property (pclken && tx_st_r == TX_IDLE && !tx_packet_start // RL2
		|=> tx_st_r == TX_IDLE && !tx_packet_end)
		else $error("Idle transmit tracker moved without a start.");
	// A start inside a packet must not restart the byte count.
	AST_START_BUSY: assert property (pclken && tx_st_r == TX_BUSY && tx_packet_start // RL2
		&& !tx_byte_strobe |=> tx_st_r == TX_BUSY && sent_r == $past(sent_r))
		else $error("Start inside a packet disturbed the count.");

endmodule // udpc_top
`default_nettype wire

//--- udpc_host_model.sv
// Far-side model: USB host traffic as the endpoint control block sees it.
// Assumes the bench calls its tasks from the pclk domain.
`default_nettype none
module udpc_host_model (
	input  wire logic        pclk,            // Block clock.
	output logic             tx_packet_start, // IN packet begins.
	output logic             tx_byte_strobe,  // One byte sent.
	output logic             rx_out_packet,   // OUT packet received.
	output logic [11:0]      rx_packet_size,  // Size of the last OUT packet.
	output logic             dma_total_zero   // Total transfer count hit zero.
);
	timeunit 1ns;
	timeprecision 1ns;
	// Idle levels; the size holds like a FIFO status word between packets.
	initial begin
		tx_packet_start = 1'b0;
		tx_byte_strobe = 1'b0;
		rx_out_packet = 1'b0;
		rx_packet_size = 12'h000;
		dma_total_zero = 1'b0;
	end
	// IN packet of n bytes; returns at the edge that takes the last event.
	task automatic send_in(input int n);
		@(posedge pclk) tx_packet_start <= 1'b1;
		@(posedge pclk) tx_packet_start <= 1'b0;
		repeat (n) begin
			tx_byte_strobe <= 1'b1;
			@(posedge pclk);
		end
		tx_byte_strobe <= 1'b0;
	endtask
	// OUT packet of the given size, one pulse.
	task automatic out_pkt(input logic [11:0] size);
		@(posedge pclk);
		rx_packet_size <= size;
		rx_out_packet <= 1'b1;
		@(posedge pclk) rx_out_packet <= 1'b0;
	endtask
	// End of a DMA run, one pulse.
	task automatic end_dma();
		@(posedge pclk) dma_total_zero <= 1'b1;
		@(posedge pclk) dma_total_zero <= 1'b0;
	endtask
endmodule // udpc_host_model
`default_nettype wire

//--- test_usb_device_dma_packet_control.sv
// Self-checking bench for the endpoint packet and DMA control block.
// Assumes udpc_top and udpc_host_model; APB master tasks drive the registers.
`include "udpc_defs.svh"
`default_nettype none
module test_usb_device_dma_packet_control import udpc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic        pclk, presetn, pclken, psel, penable, pwrite, pready, pslverr, err;
	logic [31:0] paddr, pwdata, prdata, rd;
	logic        tx_packet_start, tx_byte_strobe, tx_packet_end, rx_out_packet;
	logic        dma_total_zero, burst, demand, txrun, rxrun, dmasel;
	logic [11:0] rx_packet_size, dma_fifo_count;
	logic [10:0] max_packet_bytes, dma_transfer_count;
	int          mismatches, n_compared, n_end, n_base;
	logic [31:0] adr [5] = '{`UDPC_OFS_TXCNT, `UDPC_OFS_MAX_PACKET_BYTES, `UDPC_OFS_DCTL,
		`UDPC_OFS_DTC, `UDPC_OFS_DFC};
	logic [31:0] msk [5] = '{32'h3ff, 32'h400, 32'h3f, 32'h7ff, 32'hfff};
	udpc_top udpc_top_inst (.pclk(pclk), .presetn(presetn), .pclken(pclken), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr),
		.tx_packet_start(tx_packet_start), .tx_byte_strobe(tx_byte_strobe),
		.tx_packet_end(tx_packet_end), .rx_out_packet(rx_out_packet),
		.rx_packet_size(rx_packet_size), .dma_total_zero(dma_total_zero),
		.max_packet_bytes(max_packet_bytes), .dma_transfer_count(dma_transfer_count),
		.dma_fifo_count(dma_fifo_count), .burst_mode_enable(burst),
		.demand_mode_enable(demand), .tx_dma_run(txrun), .rx_dma_run(rxrun),
		.dma_mode_select(dmasel));
	udpc_host_model udpc_host_model_inst (.pclk(pclk), .tx_packet_start(tx_packet_start),
		.tx_byte_strobe(tx_byte_strobe), .rx_out_packet(rx_out_packet),
		.rx_packet_size(rx_packet_size), .dma_total_zero(dma_total_zero));
	// Clock at 10 MHz.
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	// Counts end pulses so a doubled or missing pulse shows.
	always @(posedge pclk) begin
		if (tx_packet_end === 1'b1) n_end <= n_end + 1;
	end
	// -----------------------------------------------------------------
	// Bus and report tasks
	// -----------------------------------------------------------------
	task automatic conclude();
		$display("Compared %0d, mismatched %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask
	// One APB transfer; the request stands until pready is seen high, or for 20 cycles, after which the bench ends.
	task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk) penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (pready !== 1'b1) begin
			mismatches++;
			conclude();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Main sequence: reset held for five cycles, then the tests in turn.
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		pclken = 1'b1;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		foreach (adr[k]) begin
			apb(1'b0, adr[k], 32'h0);
			chk("reset value", 32'h0, rd);
			apb(1'b1, adr[k], 32'hffff_ffff);
			apb(1'b0, adr[k], 32'h0);
			chk("field width", msk[k], rd);
		end
		chk("max packet pins", 32'h400, {21'h0, max_packet_bytes});
		apb(1'b0, 32'h4980_0034, 32'h0);
		chk("unmapped read", 32'h1, {rd[30:0], err});
		chk("unmapped data", 32'h0, rd);
		$display("Test registers done");
		for (int b = 0; b < 6; b++) begin
			apb(1'b1, `UDPC_OFS_DCTL, 32'h1 << b);
			apb(1'b0, `UDPC_OFS_DCTL, 32'h0);
			chk("control", 32'h1 << b, rd);
			chk("control pins", (32'h1 << b) & 32'h1f,
				{27'h0, burst, demand, txrun, rxrun, dmasel});
		end
		$display("Test control bits done");
		// Counts 0, 3 and 1023, each below the max packet size of 1024.
		foreach (msk[k]) begin
			if (k > 2) break;
			apb(1'b1, `UDPC_OFS_TXCNT, (k == 0) ? 0 : (k == 1) ? 3 : 32'h3ff);
			n_base = n_end;
			udpc_host_model_inst.send_in((k == 0) ? 0 : (k == 1) ? 3 : 1023);
			#1;
			chk("packet end", 32'h1, {31'h0, tx_packet_end});
			@(posedge pclk);
			#1;
			chk("packet end count", 32'h1, n_end - n_base);
		end
		$display("Test transmit end done");
		// Auto run only with DMA mode set and the disable bit clear.
		for (int k = 0; k < 3; k++) begin
			apb(1'b1, `UDPC_OFS_DCTL, (k == 0) ? 32'h01 : (k == 1) ? 32'h21 : 32'h00);
			udpc_host_model_inst.out_pkt(12'h1a5 + 12'(k));
			#1;
			chk("auto receive run", (k == 0) ? 32'h1 : 32'h0, {31'h0, rxrun});
		end
		apb(1'b0, `UDPC_OFS_DFC, 32'h0);
		chk("fifo count auto", 32'h1a5, rd);
		apb(1'b1, `UDPC_OFS_DCTL, 32'h02);
		apb(1'b0, `UDPC_OFS_DFC, 32'h0);
		chk("fifo count soft", 32'h1a7, rd);
		$display("Test receive run done");
		apb(1'b1, `UDPC_OFS_DCTL, 32'h21);
		// A low clock enable must swallow the end pulse.
		pclken <= 1'b0;
		udpc_host_model_inst.end_dma();
		pclken <= 1'b1;
		apb(1'b0, `UDPC_OFS_DCTL, 32'h0);
		chk("disable frozen", 32'h21, rd);
		udpc_host_model_inst.end_dma();
		apb(1'b0, `UDPC_OFS_DCTL, 32'h0);
		chk("disable cleared", 32'h1, rd);
		$display("Test run end done");
		// Single mode wants a count of two, burst mode the max packet size.
		apb(1'b1, `UDPC_OFS_DTC, 32'h2);
		#1;
		chk("single count pins", 32'h2, {21'h0, dma_transfer_count});
		apb(1'b1, `UDPC_OFS_DCTL, 32'h11);
		apb(1'b1, `UDPC_OFS_DTC, 32'h400);
		apb(1'b1, `UDPC_OFS_DFC, 32'h400);
		apb(1'b1, `UDPC_OFS_DCTL, 32'h15);
		#1;
		chk("burst count pins", 32'h400, {21'h0, dma_transfer_count});
		chk("fifo count pins", 32'h400, {20'h0, dma_fifo_count});
		chk("in run pins", 32'h15, {27'h0, burst, demand, txrun, rxrun, dmasel});
		$display("Test transfer counts done");
		// A reset in mid-run clears every register again.
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `UDPC_OFS_DCTL, 32'h0);
		chk("control after reset", 32'h0, rd);
		chk("reset pins", 32'h0, {9'h0, dma_transfer_count, dma_fifo_count});
		$display("Test reset done");
		conclude();
	end
endmodule // test_usb_device_dma_packet_control
`default_nettype wire
